/* File: pkg/dbag_defines.vh */
`ifndef DBAG_DEFINES_VH
`define DBAG_DEFINES_VH

// service access bus address layout
`define DBAG_AW 36
`define DBAG_SLV_W 4
// window bases and ends (end is exclusive)
`define DBAG_SEC_FLASH_BASE 36'h580000000
`define DBAG_SEC_RAM_BASE 36'h500000000
`define DBAG_UPAGE_START 36'h580800000
`define DBAG_UPAGE_END 36'h581000000
`define DBAG_MBOX_START 36'h100000110
`define DBAG_MBOX_END 36'h100000118
`define DBAG_FCTL_START 36'h5FFFE0000
`define DBAG_FCTL_END 36'h5FFFE0400
`define DBAG_FLASH_BASE 36'h580000000
`define DBAG_LEN_SHIFT 10
// default flash size in bytes
`define DBAG_FLASH_SIZE_DEF 32'h00040000
// register reset values
`define DBAG_UPAGE_RST 32'h00000000
`define DBAG_BOOT_RST 32'h00000000
`define DBAG_BCNT_RST 32'h00000000

// apb register byte offsets
`define DBAG_OFF_CTRL 12'h000
`define DBAG_OFF_UPAGE 12'h004
`define DBAG_OFF_BOOT 12'h008
`define DBAG_OFF_FSIZE 12'h00C
`define DBAG_OFF_STAT 12'h010
`define DBAG_OFF_LAST 12'h014
`define DBAG_OFF_BCNT 12'h018

// control bits
`define DBAG_CTRL_SECURE 0
`define DBAG_CTRL_SECBIT 1
`define DBAG_CTRL_USER_CODE_PROGRAMMING_PROTECT 2
`define DBAG_CTRL_RST 32'h00000000

// decision codes in status
`define DBAG_DEC_NORMAL 2'h0
`define DBAG_DEC_SECURE 2'h1
`define DBAG_DEC_SECBIT 2'h2
`define DBAG_DEC_UCP 2'h3

`endif

/* File: hdl/dbag_guard.v */
// Function
// RULE_01: decide per bus access whether address is allowed or blocked, per control bits
// RULE_02: secure mode blocks secure flash window and secure RAM window
// RULE_03: window lengths from user page word: low/high halves shifted left by 10
// RULE_04: secure mode: user page read-only; all else passes normally
// RULE_05: security bit: mailbox/status registers read/write, user page read, rest blocked
// RULE_06: programming protect plus security bit: also flash controller interface read/write
// RULE_07: programming mode: flash beyond boot-protected size read/write, rest blocked
// RULE_08: addresses are 36 bits; top 4 select slave; full address compared
// RULE_09: security bit alone uses its list; with programming protect, that list instead
`timescale 1ns/100ps
`include "dbag_defines.vh"

module dbag_guard (
  // clock and reset
  input wire clock,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // access request from debug bus master
  input wire req_valid,
  input wire [`DBAG_AW-1:0] req_addr,
  input wire req_write,
  // decision, one cycle after request
  output reg resp_valid,
  output reg resp_allow,
  output reg resp_block
);

  // settings written over apb
  reg [31:0] ctrl_reg;
  reg [31:0] upage_reg;
  reg [31:0] boot_reg;
  reg [31:0] fsize_reg;
  // what software can observe
  reg [1:0] dec_reg;
  reg [`DBAG_AW-1:0] last_reg;
  reg [31:0] bcnt_reg;

  wire secure_on = ctrl_reg[`DBAG_CTRL_SECURE];
  wire secbit_on = ctrl_reg[`DBAG_CTRL_SECBIT];
  wire user_code_programming_protect_on = ctrl_reg[`DBAG_CTRL_USER_CODE_PROGRAMMING_PROTECT];

  // window lengths, 16 bits shifted by 10 fit well inside 36 bits [RULE_03]
  wire [`DBAG_AW-1:0] flash_len = {20'h00000, upage_reg[15:0]} << `DBAG_LEN_SHIFT;
  wire [`DBAG_AW-1:0] ram_len = {20'h00000, upage_reg[31:16]} << `DBAG_LEN_SHIFT;
  wire [`DBAG_AW-1:0] boot_len = {4'h0, boot_reg};
  wire [`DBAG_AW-1:0] flash_sz = {4'h0, fsize_reg};

  // window table; a window of length zero never hits
  localparam WIN_N = 6;
  localparam WIN_SFL = 0;
  localparam WIN_SRAM = 1;
  localparam WIN_UPG = 2;
  localparam WIN_MBX = 3;
  localparam WIN_FCTL = 4;
  localparam WIN_UFL = 5;
  wire [`DBAG_AW-1:0] win_lo [0:WIN_N-1];
  wire [`DBAG_AW-1:0] win_hi [0:WIN_N-1];
  wire [WIN_N-1:0] win_hit;

  assign win_lo[WIN_SFL] = `DBAG_SEC_FLASH_BASE; // [RULE_02]
  assign win_hi[WIN_SFL] = `DBAG_SEC_FLASH_BASE + flash_len;
  assign win_lo[WIN_SRAM] = `DBAG_SEC_RAM_BASE; // [RULE_02]
  assign win_hi[WIN_SRAM] = `DBAG_SEC_RAM_BASE + ram_len;
  assign win_lo[WIN_UPG] = `DBAG_UPAGE_START; // [RULE_04]
  assign win_hi[WIN_UPG] = `DBAG_UPAGE_END;
  assign win_lo[WIN_MBX] = `DBAG_MBOX_START; // [RULE_05]
  assign win_hi[WIN_MBX] = `DBAG_MBOX_END;
  assign win_lo[WIN_FCTL] = `DBAG_FCTL_START; // [RULE_06]
  assign win_hi[WIN_FCTL] = `DBAG_FCTL_END;
  // boot-protected pages stay closed even to the programming list
  assign win_lo[WIN_UFL] = `DBAG_FLASH_BASE + boot_len; // [RULE_07]
  assign win_hi[WIN_UFL] = `DBAG_FLASH_BASE + flash_sz;

  genvar wi;
  generate
    for (wi = 0; wi < WIN_N; wi = wi + 1) begin : g_win
      // end-exclusive, full 36-bit compare with the slave nibble [RULE_08]
      assign win_hit[wi] = (req_addr >= win_lo[wi]) && (req_addr < win_hi[wi]);
    end
  endgenerate

  wire in_sec_flash = win_hit[WIN_SFL];
  wire in_sec_ram = win_hit[WIN_SRAM];
  wire in_upage = win_hit[WIN_UPG];
  wire in_mbox = win_hit[WIN_MBX];
  wire in_fctl = win_hit[WIN_FCTL];
  wire in_uflash = win_hit[WIN_UFL];

  // allow term of each access list
  wire page_read = in_upage && !req_write;
  wire allow_sec_list = in_mbox || page_read; // [RULE_05]
  wire allow_ucp_list = allow_sec_list || in_fctl || in_uflash; // [RULE_06] [RULE_07]
  // user page checked first: it lies inside the flash window when that is large [RULE_04]
  wire allow_secure = in_upage ? !req_write : !(in_sec_flash || in_sec_ram); // [RULE_02]

  reg allow_c;
  reg [1:0] dec_c;
  always @* begin
    allow_c = 1'b1;
    dec_c = `DBAG_DEC_NORMAL;
    // first match wins: programming list, then security bit, then secure mode [RULE_01]
    if (secbit_on && user_code_programming_protect_on) begin
      dec_c = `DBAG_DEC_UCP; // [RULE_09]
      allow_c = allow_ucp_list;
    end else if (secbit_on) begin
      dec_c = `DBAG_DEC_SECBIT; // [RULE_09]
      allow_c = allow_sec_list;
    end else if (secure_on) begin
      dec_c = `DBAG_DEC_SECURE;
      allow_c = allow_secure;
    end
  end

  wire blk_evt = req_valid && !allow_c;

  // verdict, one cycle after the request
  always @(posedge clock) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_allow <= 1'b0;
      resp_block <= 1'b0;
    end else begin
      resp_valid <= req_valid;
      resp_allow <= req_valid && allow_c; // [RULE_01]
      resp_block <= blk_evt; // [RULE_01]
    end
  end

  // active list and last blocked address
  always @(posedge clock) begin
    if (rst) begin
      dec_reg <= `DBAG_DEC_NORMAL;
      last_reg <= {`DBAG_AW{1'b0}};
    end else begin
      dec_reg <= dec_c;
      if (blk_evt)
        last_reg <= req_addr;
    end
  end

  // apb slave: every access phase gets exactly one wait state
  wire apb_acc = psel && penable && !pready;
  // settings change only at the edge that completes the transfer
  wire apb_done = psel && penable && pready;
  wire apb_wr = apb_done && pwrite;
  wire bcnt_clr = apb_wr && (paddr == `DBAG_OFF_BCNT);

  always @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= `DBAG_CTRL_RST;
      upage_reg <= `DBAG_UPAGE_RST;
      boot_reg <= `DBAG_BOOT_RST;
      fsize_reg <= `DBAG_FLASH_SIZE_DEF;
    end else if (apb_wr) begin
      case (paddr)
        `DBAG_OFF_CTRL: ctrl_reg <= {29'h0000000, pwdata[2:0]};
        `DBAG_OFF_UPAGE: upage_reg <= pwdata;
        `DBAG_OFF_BOOT: boot_reg <= pwdata;
        `DBAG_OFF_FSIZE: fsize_reg <= pwdata;
        // status, last and unmapped offsets ignore writes; a BCNT write clears the blocked count
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // blocked count; a block in the clearing cycle still counts as one
  always @(posedge clock) begin
    if (rst) begin
      bcnt_reg <= `DBAG_BCNT_RST;
    end else if (blk_evt) begin
      if (bcnt_clr)
        bcnt_reg <= 32'h00000001;
      else
        bcnt_reg <= bcnt_reg + 32'h00000001;
    end else if (bcnt_clr) begin
      bcnt_reg <= 32'h00000000;
    end
  end

  reg [31:0] rd_c;
  reg err_c;
  always @* begin
    rd_c = 32'h00000000;
    err_c = 1'b0;
    case (paddr)
      `DBAG_OFF_CTRL: rd_c = ctrl_reg;
      `DBAG_OFF_UPAGE: rd_c = upage_reg;
      `DBAG_OFF_BOOT: rd_c = boot_reg;
      `DBAG_OFF_FSIZE: rd_c = fsize_reg;
      `DBAG_OFF_STAT: rd_c = {26'h0000000, last_reg[35:32], dec_reg};
      `DBAG_OFF_LAST: rd_c = last_reg[31:0];
      `DBAG_OFF_BCNT: rd_c = bcnt_reg;
      default: err_c = 1'b1;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_acc;
      // error rides on the answer pulse, never later
      pslverr <= apb_acc && err_c;
      // read data zero outside reads keeps stale settings off the bus
      if (psel && !pwrite)
        prdata <= rd_c;
      else
        prdata <= 32'h00000000;
    end
  end

endmodule // dbag_guard

/* File: testbench/dbag_guard_monitor.sv */
`timescale 1ns/100ps
module dbag_guard_monitor (
  input wire clock, rst, psel, penable, pwrite, pready, pslverr,
  input wire req_valid, req_write, resp_valid, resp_allow, resp_block,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire [35:0] req_addr
);
  reg [2:0] c;
  // mirror of control bits; bench never mixes requests with ctrl writes
  always @(posedge clock)
    if (rst) c <= 3'h0;
    else if (psel && penable && pready && pwrite && paddr == 12'h000) c <= pwdata[2:0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  resp_once_a: assert property (req_valid |=> resp_valid) else $error("no answer");
  one_verdict_a: assert property (resp_valid |-> resp_allow ^ resp_block) else $error("bad verdict");
  plain_pass_a: assert property (req_valid && c == 3'h0 |=> resp_allow) else $error("open blocked");
  upage_wr_a: assert property (req_valid && c[0] && req_write && req_addr == 36'h580800000 |=> resp_block)
    else $error("page write");
  mbox_open_a: assert property (req_valid && c[1] && req_addr == 36'h100000110 |=> resp_allow)
    else $error("mailbox");
  slave_shut_a: assert property (req_valid && c[1] && req_addr[35:32] == 4'h6 |=> resp_block)
    else $error("slave open");
  fctl_open_a: assert property (req_valid && c == 3'h6 && req_addr == 36'h5FFFE0000 |=> resp_allow)
    else $error("fctl");
  apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("wait state");
endmodule // dbag_guard_monitor
bind dbag_guard dbag_guard_monitor mon (.*);

/* File: testbench/dbag_master_model.sv */
`timescale 1ns/100ps
module dbag_master_model (
  input wire clock,
  output logic req_valid = 0,
  output logic [35:0] req_addr = 0,
  output logic req_write = 0
);
  task issue(input logic [35:0] a, input logic w);
    @(posedge clock);
    req_valid <= 1;
    req_addr <= a;
    req_write <= w;
    @(posedge clock);
    req_valid <= 0;
    // stale lines must not look like a live request
    req_addr <= ~a;
    req_write <= ~w;
  endtask
endmodule // dbag_master_model

/* File: testbench/dbag_guard_bench.sv */
`timescale 1ns/100ps
module dbag_guard_bench;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 0, prdata, q, uw = 32'h00020004, bp = 32'h2000;
  logic pready, pslverr, req_valid, req_write, resp_valid, resp_allow, resp_block;
  logic [35:0] req_addr;
  logic [2:0] ctl;
  logic [1:0] dc;
  logic [35:0] lb = 0;
  logic [2:0] md [6] = '{0, 1, 2, 3, 4, 6};
  logic [35:0] at [17] = '{36'h580800000, 36'h580FFFFFC, 36'h581000000, 36'h100000110, 36'h100000118,
    36'h000000110, 36'h5FFFE0000, 36'h5FFFE0400, 36'h580000FFC, 36'h580001000, 36'h5000007FC,
    36'h500000800, 36'h580002000, 36'h58003FFFC, 36'h580040000, 36'h600000000, 36'h0};
  int error_cnt = 0, tests_run = 0, cyc = 0, nb = 0;
  always #10 clock = ~clock;
  dbag_guard uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_addr(req_addr), .req_write(req_write), .resp_valid(resp_valid), .resp_allow(resp_allow),
    .resp_block(resp_block));
  dbag_master_model mdl (.clock(clock), .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write));
  function automatic bit ex(logic [35:0] a, logic w);
    bit up = a >= 36'h580800000 && a < 36'h581000000;
    if (ctl[1]) begin
      if (a >= 36'h100000110 && a < 36'h100000118) return 1;
      if (up) return !w;
      return ctl[2] && ((a >= 36'h5FFFE0000 && a < 36'h5FFFE0400) ||
        (a >= 36'h580000000 + bp && a < 36'h580040000));
    end
    if (ctl[0]) begin
      if (up) return !w;
      if (a >= 36'h580000000 && a < 36'h580000000 + (uw[15:0] << 10)) return 0;
      if (a >= 36'h500000000 && a < 36'h500000000 + (uw[31:16] << 10)) return 0;
    end
    return 1;
  endfunction
  task chk(string n, logic [31:0] x, logic [31:0] s);
    tests_run++;
    if (s !== x) begin
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      error_cnt++;
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge clock);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) if (++cyc > 5000) begin error_cnt++; tally_and_finish; end
  initial begin
    void'($urandom(32'ha3fb8db7));
    repeat (3) @(posedge clock);
    rst <= 0;
    apb(12'h004, 1, uw);
    apb(12'h008, 1, bp);
    apb(12'h01C, 0, $urandom);
    chk("unmapped", 1, e);
    foreach (md[i]) begin
      ctl = md[i];
      apb(12'h000, 1, {29'h0, ctl});
      apb(12'h000, 0, 0);
      chk("ctrl", {29'h0, ctl}, q);
      at[16] = 36'h580000000 + ($urandom & 32'h3FFFC);
      foreach (at[j]) for (int w = 0; w < 2; w++) begin
        mdl.issue(at[j], w[0]);
        if (!ex(at[j], w[0])) begin
          nb++;
          lb = at[j];
        end
        #1 chk("allow", ex(at[j], w[0]), resp_allow);
      end
      dc = ctl[1] ? (ctl[2] ? 2'h3 : 2'h2) : (ctl[0] ? 2'h1 : 2'h0);
      apb(12'h010, 0, 0);
      chk("status", {26'h0, lb[35:32], dc}, q);
      apb(12'h014, 0, 0);
      chk("last", lb[31:0], q);
      apb(12'h018, 0, 0);
      chk("blocked", nb, q);
      apb(12'h018, 1, $urandom);
      nb = 0;
      $display("mode %0d done", ctl);
    end
    tally_and_finish;
  end
endmodule // dbag_guard_bench
